// file: hw/acr_clk_div.sv
// Conversion clock tick generator dividing the system clock by the selected ratio.
`timescale 1ns/100ps
`include "acr_params.svh"
module acr_clk_div #(
    parameter int DIV_CODE0 = 2
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Selection and tick
    input wire logic [2:0] clk_sel,
    output logic tick
);
    if (DIV_CODE0 < 2 || DIV_CODE0 > 128) begin : g_chk
        $error("DIV_CODE0 must lie in 2..128");
    end

    acr_pkg::acr_div_state_t s_q, s_d;
    logic [7:0] ratio;
    logic is_rc;

    always_comb begin
        unique case (s_q.sel)
            `ACR_CS_DIV8: ratio = `ACR_RATIO_DIV8;
            `ACR_CS_DIV32: ratio = `ACR_RATIO_DIV32;
            `ACR_CS_DIV4: ratio = `ACR_RATIO_DIV4;
            `ACR_CS_DIV16: ratio = `ACR_RATIO_DIV16;
            `ACR_CS_DIV64: ratio = `ACR_RATIO_DIV64;
            `ACR_CS_RC_A, `ACR_CS_RC_B: ratio = 8'h01;
            `ACR_CS_DIV_ALT: ratio = 8'(DIV_CODE0);
        endcase
        is_rc = (s_q.sel == `ACR_CS_RC_A) || (s_q.sel == `ACR_CS_RC_B);
        s_d = s_q;
        s_d.sel = clk_sel;
        // A new selection restarts the count so no short period leaks out.
        if (clk_sel != s_q.sel || is_rc) begin
            s_d.cnt = 7'h00;
            s_d.tick = 1'b0;
        end else if ({1'b0, s_q.cnt} == ratio - 8'h01) begin
            s_d.cnt = 7'h00;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 7'h01;
            s_d.tick = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;

    sequence s_div4_run;
        (tick && clk_sel == `ACR_CS_DIV4) ##1 (clk_sel == `ACR_CS_DIV4)[*3];
    endsequence

    a_div4_period: assert property (@(posedge aclk) disable iff (!aresetn)
        s_div4_run |=> tick)
        else $error("divide-by-4 tick not four cycles apart");
    a_tick_single: assert property (@(posedge aclk) disable iff (!aresetn)
        tick |=> !tick)
        else $error("conversion tick lasted more than one cycle");
endmodule

// file: hw/acr_params.svh
// Register offsets, field positions, reset values and clock division ratios.
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH
`define ACR_OFF_CTRL 32'h0000_0000
`define ACR_OFF_RES_HI 32'h0000_0004
`define ACR_OFF_RES_LO 32'h0000_0008
`define ACR_CTRL_RESET 8'h00
`define ACR_RES_RESET 8'h00
`define ACR_CTRL_WMASK 8'hF7
`define ACR_FMT_BIT 7
`define ACR_CS_MSB 6
`define ACR_CS_LSB 4
`define ACR_UNIMP_BIT 3
`define ACR_NREF_BIT 2
`define ACR_PREF_MSB 1
`define ACR_PREF_LSB 0
`define ACR_CS_DIV_ALT 3'h0
`define ACR_CS_DIV8 3'h1
`define ACR_CS_DIV32 3'h2
`define ACR_CS_RC_A 3'h3
`define ACR_CS_DIV4 3'h4
`define ACR_CS_DIV16 3'h5
`define ACR_CS_DIV64 3'h6
`define ACR_CS_RC_B 3'h7
`define ACR_RATIO_DIV8 8'h08
`define ACR_RATIO_DIV32 8'h20
`define ACR_RATIO_DIV4 8'h04
`define ACR_RATIO_DIV16 8'h10
`define ACR_RATIO_DIV64 8'h40
`define ACR_RESP_OKAY 2'h0
`define ACR_RESP_SLVERR 2'h2
`endif

// file: hw/acr_pkg.sv
// Types shared by the converter configuration and result register block.
package acr_pkg;
    typedef struct packed {
        logic awvalid;
        logic [31:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [31:0] araddr;
        logic rready;
    } acr_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } acr_axi_rsp_t;

    typedef struct packed {
        logic [6:0] cnt;
        logic [2:0] sel;
        logic tick;
    } acr_div_state_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] res_hi;
        logic [7:0] res_lo;
        logic aw_have;
        logic [31:0] awaddr;
        logic w_have;
        logic [7:0] wdata;
        logic wstrb0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic rd_ctrl;
        logic use_rc;
        logic nref;
        logic [1:0] pref;
    } acr_state_t;
endpackage

// file: hw/acr_top.sv
// Converter configuration and result registers behind an AXI4-Lite slave.
`timescale 1ns/100ps
`include "acr_params.svh"
module acr_top #(
    parameter int DIV_CODE0 = 2,
    parameter int RES_W = 10
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire acr_pkg::acr_axi_req_t axi_req,
    output acr_pkg::acr_axi_rsp_t axi_rsp,
    // Converter core result, on the same clock
    input wire logic result_valid,
    input wire logic [9:0] conversion_result,
    // Converter core configuration
    output logic conv_clk_tick,
    output logic use_rc_clock,
    output logic result_format_select,
    output logic negative_reference_select,
    output logic [1:0] positive_reference_select
);
    if (RES_W != 10) begin : g_chk
        $error("RES_W must be 10");
    end

    // ----------------------------------------------------------------
    // State update
    // ----------------------------------------------------------------
    acr_pkg::acr_state_t s_q, s_d;
    logic aw_fire;
    logic w_fire;
    logic ar_fire;
    logic wr_go;
    logic [2:0] cs_d;

    always_comb begin
        s_d = s_q;
        aw_fire = axi_req.awvalid && s_q.awready;
        w_fire = axi_req.wvalid && s_q.wready;
        ar_fire = axi_req.arvalid && s_q.arready;
        wr_go = s_q.aw_have && s_q.w_have && !s_q.bvalid;
        if (aw_fire) begin
            s_d.aw_have = 1'b1;
            s_d.awaddr = axi_req.awaddr;
        end
        if (w_fire) begin
            s_d.w_have = 1'b1;
            s_d.wdata = axi_req.wdata[7:0];
            s_d.wstrb0 = axi_req.wstrb[0];
        end
        if (s_q.bvalid && axi_req.bready) begin
            s_d.bvalid = 1'b0;
        end
        // Address and data may arrive in either order; the write is done
        // once both are held, so a response never precedes its data.
        if (wr_go) begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = `ACR_RESP_OKAY;
            unique case (s_q.awaddr)
                `ACR_OFF_CTRL: begin
                    if (s_q.wstrb0) begin
                        s_d.ctrl = s_q.wdata & `ACR_CTRL_WMASK;
                    end
                end
                `ACR_OFF_RES_HI: begin
                    if (s_q.wstrb0) begin
                        s_d.res_hi = s_q.wdata;
                    end
                end
                `ACR_OFF_RES_LO: begin
                    if (s_q.wstrb0) begin
                        s_d.res_lo = s_q.wdata;
                    end
                end
                default: s_d.bresp = `ACR_RESP_SLVERR;
            endcase
        end
        // A finished conversion overrides a software write to the result registers in the same cycle.
        if (result_valid) begin
            if (!s_q.ctrl[`ACR_FMT_BIT]) begin
                s_d.res_hi = conversion_result[9:2];
                s_d.res_lo = {conversion_result[1:0], 6'h00};
            end else begin
                s_d.res_hi = {6'h00, conversion_result[9:8]};
                s_d.res_lo = conversion_result[7:0];
            end
        end
        if (s_q.rvalid && axi_req.rready) begin
            s_d.rvalid = 1'b0;
        end
        if (ar_fire) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = `ACR_RESP_OKAY;
            s_d.rd_ctrl = 1'b0;
            unique case (axi_req.araddr)
                `ACR_OFF_CTRL: begin
                    s_d.rdata = s_q.ctrl & `ACR_CTRL_WMASK;
                    s_d.rd_ctrl = 1'b1;
                end
                `ACR_OFF_RES_HI: s_d.rdata = s_q.res_hi;
                `ACR_OFF_RES_LO: s_d.rdata = s_q.res_lo;
                default: begin
                    s_d.rdata = 8'h00;
                    s_d.rresp = `ACR_RESP_SLVERR;
                end
            endcase
        end
        s_d.awready = !s_d.aw_have;
        s_d.wready = !s_d.w_have;
        s_d.arready = !s_d.rvalid;
        cs_d = s_d.ctrl[`ACR_CS_MSB:`ACR_CS_LSB];
        s_d.use_rc = (cs_d == `ACR_CS_RC_A) || (cs_d == `ACR_CS_RC_B);
        s_d.nref = s_d.ctrl[`ACR_NREF_BIT];
        // Code 01 is stored as written; software is expected never to use it.
        s_d.pref = s_d.ctrl[`ACR_PREF_MSB:`ACR_PREF_LSB];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
            s_q.ctrl <= `ACR_CTRL_RESET;
            s_q.res_hi <= `ACR_RES_RESET;
            s_q.res_lo <= `ACR_RES_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Conversion clock
    // ----------------------------------------------------------------
    acr_clk_div #(
        .DIV_CODE0(DIV_CODE0)
    ) u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_sel(s_q.ctrl[`ACR_CS_MSB:`ACR_CS_LSB]),
        .tick(conv_clk_tick)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign axi_rsp.awready = s_q.awready;
    assign axi_rsp.wready = s_q.wready;
    assign axi_rsp.bvalid = s_q.bvalid;
    assign axi_rsp.bresp = s_q.bresp;
    assign axi_rsp.arready = s_q.arready;
    assign axi_rsp.rvalid = s_q.rvalid;
    assign axi_rsp.rdata = {24'h00_0000, s_q.rdata};
    assign axi_rsp.rresp = s_q.rresp;
    assign use_rc_clock = s_q.use_rc;
    assign result_format_select = s_q.ctrl[`ACR_FMT_BIT];
    assign negative_reference_select = s_q.nref;
    assign positive_reference_select = s_q.pref;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic ctrl_wr;
    assign ctrl_wr = wr_go && s_q.awaddr == `ACR_OFF_CTRL && s_q.wstrb0;

    sequence s_rc_write;
        ctrl_wr && (s_q.wdata[`ACR_CS_MSB:`ACR_CS_LSB] == `ACR_CS_RC_A ||
            s_q.wdata[`ACR_CS_MSB:`ACR_CS_LSB] == `ACR_CS_RC_B);
    endsequence

    sequence s_rc_quiet;
        ##1 (!conv_clk_tick)[*4];
    endsequence

    a_left_high: assert property (@(posedge aclk) disable iff (!aresetn)
        (result_valid && !s_q.ctrl[`ACR_FMT_BIT]) |=>
            s_q.res_hi == $past(conversion_result[9:2]))
        else $error("left justified high byte wrong");
    a_left_low: assert property (@(posedge aclk) disable iff (!aresetn)
        (result_valid && !s_q.ctrl[`ACR_FMT_BIT]) |=>
            s_q.res_lo[7:6] == $past(conversion_result[1:0]))
        else $error("left justified low bits wrong");
    a_right_split: assert property (@(posedge aclk) disable iff (!aresetn)
        (result_valid && s_q.ctrl[`ACR_FMT_BIT]) |=>
            {s_q.res_hi, s_q.res_lo} == {6'h00, $past(conversion_result)})
        else $error("right justified result wrong");
    a_rc_select: assert property (@(posedge aclk) disable iff (!aresetn)
        s_rc_write |=> use_rc_clock ##0 s_rc_quiet)
        else $error("RC clock code did not stop divided ticks");
    a_neg_ref: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_wr |=> negative_reference_select == $past(s_q.wdata[`ACR_NREF_BIT]))
        else $error("negative reference select not applied");
    a_pos_ref: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_wr |=> positive_reference_select == $past(s_q.wdata[1:0]))
        else $error("positive reference select not applied");
    a_fvr_code: assert property (@(posedge aclk) disable iff (!aresetn)
        (ctrl_wr && s_q.wdata[1:0] == 2'h3) |=> ##1 positive_reference_select == 2'h3)
        else $error("fixed reference code not held");
    a_bit3_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_q.rvalid && s_q.rd_ctrl) |-> axi_rsp.rdata[`ACR_UNIMP_BIT] == 1'b0)
        else $error("unimplemented control bit read as one");
    a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_go && s_q.awaddr == `ACR_OFF_RES_HI) |=> axi_rsp.bvalid && axi_rsp.bresp == 2'h0)
        else $error("write response missing");

    logic wr_hit;
    logic rd_hit;
    logic res_wr;
    logic rc_code;
    assign wr_hit = s_q.awaddr == `ACR_OFF_CTRL || s_q.awaddr == `ACR_OFF_RES_HI
        || s_q.awaddr == `ACR_OFF_RES_LO;
    assign rd_hit = axi_req.araddr == `ACR_OFF_CTRL || axi_req.araddr == `ACR_OFF_RES_HI
        || axi_req.araddr == `ACR_OFF_RES_LO;
    assign res_wr = wr_go && s_q.wstrb0
        && (s_q.awaddr == `ACR_OFF_RES_HI || s_q.awaddr == `ACR_OFF_RES_LO);
    assign rc_code = s_q.wdata[`ACR_CS_MSB:`ACR_CS_LSB] == `ACR_CS_RC_A
        || s_q.wdata[`ACR_CS_MSB:`ACR_CS_LSB] == `ACR_CS_RC_B;

    // ----------------------------------------------------------------
    // Bus handshake checks
    // ----------------------------------------------------------------
    a_aw_taken: assert property (@(posedge aclk) disable iff (!aresetn)
        aw_fire |=>
            !axi_rsp.awready)
        else $error("write address ready stayed high after capture");
    a_w_taken: assert property (@(posedge aclk) disable iff (!aresetn)
        w_fire |=>
            !axi_rsp.wready)
        else $error("write data ready stayed high after capture");
    a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go |=>
            axi_rsp.bvalid && axi_rsp.awready && axi_rsp.wready)
        else $error("write completion not answered");
    a_bvalid_drop: assert property (@(posedge aclk) disable iff (!aresetn)
        (axi_rsp.bvalid && axi_req.bready) |=>
            !axi_rsp.bvalid)
        else $error("write response held after bready");
    a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_fire |=>
            axi_rsp.rvalid && !axi_rsp.arready)
        else $error("read address not answered");
    a_rvalid_drop: assert property (@(posedge aclk) disable iff (!aresetn)
        (axi_rsp.rvalid && axi_req.rready) |=>
            !axi_rsp.rvalid)
        else $error("read data held after rready");
    a_wr_decode: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go |=>
            axi_rsp.bresp == ($past(wr_hit) ? `ACR_RESP_OKAY : `ACR_RESP_SLVERR))
        else $error("write response code wrong");
    a_rd_decode: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_fire |=>
            axi_rsp.rresp == ($past(rd_hit) ? `ACR_RESP_OKAY : `ACR_RESP_SLVERR))
        else $error("read response code wrong");
    a_rd_miss_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        (ar_fire && !rd_hit) |=>
            axi_rsp.rdata == 32'h0000_0000)
        else $error("unmapped read returned data");
    a_rdata_upper: assert property (@(posedge aclk) disable iff (!aresetn)
        axi_rsp.rvalid |->
            axi_rsp.rdata[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");

    // ----------------------------------------------------------------
    // Register storage checks
    // ----------------------------------------------------------------
    a_ctrl_store: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_wr |=>
            s_q.ctrl == ($past(s_q.wdata) & `ACR_CTRL_WMASK))
        else $error("control write not stored");
    a_ctrl_read: assert property (@(posedge aclk) disable iff (!aresetn)
        (ar_fire && axi_req.araddr == `ACR_OFF_CTRL) |=>
            axi_rsp.rdata[7:0] == $past(s_q.ctrl))
        else $error("control read returned wrong value");
    a_strobe_skip: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_go && s_q.awaddr == `ACR_OFF_CTRL && !s_q.wstrb0) |=>
            $stable(s_q.ctrl))
        else $error("control changed without byte strobe");
    a_res_sw_high: assert property (@(posedge aclk) disable iff (!aresetn)
        (res_wr && s_q.awaddr == `ACR_OFF_RES_HI && !result_valid) |=>
            s_q.res_hi == $past(s_q.wdata))
        else $error("software write to high result not stored");
    a_res_sw_low: assert property (@(posedge aclk) disable iff (!aresetn)
        (res_wr && s_q.awaddr == `ACR_OFF_RES_LO && !result_valid) |=>
            s_q.res_lo == $past(s_q.wdata))
        else $error("software write to low result not stored");
    a_res_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (!result_valid && !res_wr) |=>
            $stable(s_q.res_hi) && $stable(s_q.res_lo))
        else $error("result registers changed without cause");
    a_reset_clear: assert property (@(posedge aclk)
        !aresetn |=>
            s_q.ctrl == `ACR_CTRL_RESET && s_q.res_hi == `ACR_RES_RESET
            && s_q.res_lo == `ACR_RES_RESET && !axi_rsp.bvalid && !axi_rsp.rvalid)
        else $error("reset did not clear the registers");

    // ----------------------------------------------------------------
    // Configuration output checks
    // ----------------------------------------------------------------
    a_fmt_follow: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_wr |=>
            result_format_select == $past(s_q.wdata[`ACR_FMT_BIT]))
        else $error("result format select not applied");
    a_div_select: assert property (@(posedge aclk) disable iff (!aresetn)
        (ctrl_wr && !rc_code) |=>
            !use_rc_clock)
        else $error("divided clock code selected the RC clock");
    a_rc_no_tick: assert property (@(posedge aclk) disable iff (!aresetn)
        use_rc_clock |->
            ##2 !conv_clk_tick)
        else $error("divided tick while RC clock selected");
    a_cfg_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        !ctrl_wr |=>
            $stable(positive_reference_select) && $stable(negative_reference_select)
            && $stable(result_format_select) && $stable(use_rc_clock))
        else $error("configuration changed without a control write");
endmodule

// file: tb/acr_top_test.sv
// Self-checking testbench for the converter configuration and result registers.
`timescale 1ns/100ps
`include "acr_params.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; $display("Error %0t: got %h expected %h", $time, a, e); end end
module acr_top_test;
    // ----------------------------------------
    // Signals and design instance
    // ----------------------------------------
    localparam int DIV0 = 3;
    logic aclk;
    logic aresetn;
    acr_pkg::acr_axi_req_t req;
    acr_pkg::acr_axi_rsp_t rsp;
    logic result_valid;
    logic [9:0] conversion_result;
    logic conv_clk_tick;
    logic use_rc_clock;
    logic result_format_select;
    logic negative_reference_select;
    logic [1:0] positive_reference_select;
    int n_fail = 0;
    int checked = 0;
    logic [15:0] seed;
    logic [31:0] d;
    logic [1:0] r;
    logic [9:0] v;
    int p;
    int x;
    // Reference model: register contents as integers, converter results queued.
    int m_ctrl = 0;
    int m_hi = 0;
    int m_lo = 0;
    int m_q[$];
    acr_top #(.DIV_CODE0(DIV0), .RES_W(10)) acr_top_inst (
        .aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
        .result_valid(result_valid), .conversion_result(conversion_result),
        .conv_clk_tick(conv_clk_tick), .use_rc_clock(use_rc_clock),
        .result_format_select(result_format_select),
        .negative_reference_select(negative_reference_select),
        .positive_reference_select(positive_reference_select));
    always #10 aclk = ~aclk;
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic summarize();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic hang();
        n_fail++;
        summarize();
    endtask
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic int ratio(input int c);
        case (c)
            1: return `ACR_RATIO_DIV8;
            2: return `ACR_RATIO_DIV32;
            4: return `ACR_RATIO_DIV4;
            5: return `ACR_RATIO_DIV16;
            6: return `ACR_RATIO_DIV64;
            0: return DIV0;
            default: return 0;
        endcase
    endfunction
    // Both channels are offered together; each is dropped at the edge that takes it.
    task automatic wr(input logic [31:0] a, input logic [31:0] dat, input logic [3:0] s,
                      output logic [1:0] resp);
        int n;
        bit aw;
        bit w;
        aw = 0;
        w = 0;
        n = 0;
        @(posedge aclk);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= dat;
        req.wstrb <= s;
        req.bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            n++;
            if (n > 200) hang();
            if (!aw && rsp.awready === 1'b1) begin
                aw = 1;
                req.awvalid <= 1'b0;
            end
            if (!w && rsp.wready === 1'b1) begin
                w = 1;
                req.wvalid <= 1'b0;
            end
        end
        do begin
            @(posedge aclk);
            n++;
            if (n > 400) hang();
        end while (rsp.bvalid !== 1'b1);
        resp = rsp.bresp;
        req.bready <= 1'b0;
        if (s[0]) begin
            if (a == `ACR_OFF_CTRL) m_ctrl = 32'(dat[7:0] & `ACR_CTRL_WMASK);
            if (a == `ACR_OFF_RES_HI) m_hi = 32'(dat[7:0]);
            if (a == `ACR_OFF_RES_LO) m_lo = 32'(dat[7:0]);
        end
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] dat, output logic [1:0] resp);
        int n;
        bit ar;
        ar = 0;
        n = 0;
        @(posedge aclk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (n > 400) hang();
            if (!ar && rsp.arready === 1'b1) begin
                ar = 1;
                req.arvalid <= 1'b0;
            end
        end while (rsp.rvalid !== 1'b1);
        dat = rsp.rdata;
        resp = rsp.rresp;
        req.rready <= 1'b0;
    endtask
    // Returns the spacing of two ticks, or zero when no tick comes at all.
    task automatic period(output int per);
        int n;
        n = 0;
        per = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (conv_clk_tick !== 1'b1 && n < 200);
        if (n < 200) begin
            do begin
                @(posedge aclk);
                per++;
            end while (conv_clk_tick !== 1'b1 && per < 200);
        end
    endtask
    // One converter result pulse; the model splits it by the format held before it.
    task automatic convert(input logic [9:0] res);
        @(posedge aclk);
        result_valid <= 1'b1;
        conversion_result <= res;
        @(posedge aclk);
        result_valid <= 1'b0;
        conversion_result <= ~res;
        if (m_ctrl[`ACR_FMT_BIT]) begin
            m_hi = 32'({6'h00, res[9:8]});
            m_lo = 32'(res[7:0]);
        end else begin
            m_hi = 32'(res[9:2]);
            m_lo = 32'({res[1:0], 6'h00});
        end
        m_q.push_back(m_hi);
        m_q.push_back(m_lo);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        req = '0;
        result_valid = 1'b0;
        conversion_result = '0;
        seed = 16'hD7F8;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        for (int i = 0; i < 3; i++) begin
            rd(4 * i, d, r);
            `CHK(d, 32'h0000_0000)
        end
        wr(`ACR_OFF_CTRL, 32'h0000_00FF, 4'hF, r);
        rd(`ACR_OFF_CTRL, d, r);
        `CHK(d, m_ctrl)
        `CHK(positive_reference_select, 2'h3)
        wr(`ACR_OFF_CTRL, 32'h0000_0000, 4'h0, r);
        wr(32'h0000_000C, 32'h0000_0000, 4'hF, r);
        `CHK(r, `ACR_RESP_SLVERR)
        rd(32'h0000_000C, d, r);
        `CHK(r, `ACR_RESP_SLVERR)
        rd(`ACR_OFF_CTRL, d, r);
        `CHK(d, m_ctrl)
        for (int i = 0; i < 8; i++) begin
            wr(`ACR_OFF_CTRL, 32'(i), 4'hF, r);
            `CHK(negative_reference_select, 1'(i >> 2))
            `CHK(positive_reference_select, 2'(i))
        end
        for (int i = 0; i < 8; i++) begin
            wr(`ACR_OFF_CTRL, 32'(i << 4), 4'hF, r);
            `CHK(use_rc_clock, 1'(i == 3 || i == 7))
            period(p);
            `CHK(p, ratio(i))
        end
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            v = seed[9:0];
            wr(`ACR_OFF_CTRL, 32'((i & 1) << 7), 4'hF, r);
            `CHK(result_format_select, 1'(m_ctrl >> 7))
            convert(v);
            rd(`ACR_OFF_RES_HI, d, r);
            x = m_q.pop_front();
            `CHK(d, x)
            rd(`ACR_OFF_RES_LO, d, r);
            x = m_q.pop_front();
            `CHK(d, x)
        end
        seed = lfsr(seed);
        wr(`ACR_OFF_RES_HI, 32'(seed), 4'hF, r);
        `CHK(r, `ACR_RESP_OKAY)
        wr(`ACR_OFF_RES_LO, 32'(~seed), 4'hF, r);
        rd(`ACR_OFF_RES_HI, d, r);
        `CHK(d, m_hi)
        rd(`ACR_OFF_RES_LO, d, r);
        `CHK(d, m_lo)
        // A second reset in mid-run must clear the control register and the high result register.
        aresetn <= 1'b0;
        m_ctrl = 0;
        m_hi = 0;
        m_lo = 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        `CHK(use_rc_clock, 1'b0)
        `CHK(result_format_select, 1'b0)
        rd(`ACR_OFF_CTRL, d, r);
        `CHK(d, m_ctrl)
        rd(`ACR_OFF_RES_HI, d, r);
        `CHK(d, m_hi)
        summarize();
    end
endmodule
